// *** cwd_defines.svh ***
// Offsets, field positions, reset values and timing counts of the watchdog
`ifndef CWD_DEFINES_SVH
`define CWD_DEFINES_SVH
`define CWD_ADDR_W        18
`define CWD_IDX_CONFIG    16'h0000
`define CWD_IDX_STATUS    16'h0001
`define CWD_IDX_MASK      16'h0002
`define CWD_IDX_COUNT     16'h0003
`define CWD_IDX_SERVICE   16'hffff
`define CWD_CFG_DIS       0
`define CWD_CFG_RATE      1
`define CWD_CFG_STOPEN    2
`define CWD_CFG_RESET     3'h0
`define CWD_FLAG_WDOG     0
`define CWD_PRE_KEEP      12'h00f
`define CWD_SHORT_MASK    12'h07f
`define CWD_SHORT_END     12'h06f
`define CWD_LONG_MASK     12'hfff
`define CWD_LONG_END      12'hfef
`define CWD_CNT_FULL      6'h3f
`define CWD_PIN_LOW_OSC   32
`define CWD_POR_OSC       4096
`endif

// *** cwd_pkg.sv ***
// Types shared by the watchdog modules
package cwd_pkg;
  typedef enum logic [0:0] {
    CWD_RUN   = 1'b0,
    CWD_PULSE = 1'b1
  } cwd_state_t;
endpackage

// *** cwd_sync.sv ***
// Two flip-flop synchroniser for pin levels
module cwd_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  initial begin
    if (WIDTH < 1) $error("cwd_sync: WIDTH must be at least 1");
  end
  logic [WIDTH-1:0] meta_reg;
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          meta_reg[g] <= 1'b0;
          sync_o[g]   <= 1'b0;
        end else begin
          meta_reg[g] <= async_i[g];
          sync_o[g]   <= meta_reg[g];
        end
      end
    end
  endgenerate
endmodule

// *** cwd_prescaler.sv ***
// Watchdog prescaler with full and upper-stage clears
`include "cwd_defines.svh"
module cwd_prescaler #(
  parameter int WIDTH = 12
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic             tick_i,
  input  wire logic             clear_all_i,
  input  wire logic             clear_upper_i,
  output logic      [WIDTH-1:0] value_o
);
  initial begin
    if (WIDTH != 12) $error("cwd_prescaler: taps assume a 12-bit prescaler");
  end
  logic [WIDTH-1:0] value_next;
  assign value_next = clear_all_i   ? '0 :
                      clear_upper_i ? (value_o & WIDTH'(`CWD_PRE_KEEP)) :
                      tick_i        ? WIDTH'(value_o + 1'b1) : value_o;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) value_o <= '0;
    else         value_o <= value_next;
  end
endmodule

// *** cwd_top.sv ***
// Watchdog timer top: prescaler, overflow counter, reset pulse and APB registers
//
// Overview of operation
// - Six-bit counter after twelve-bit prescaler resets system.
// - Rate bit picks short or long timeout.
// - Service write clears counter and upper prescaler.
// - Overflow drives reset pin 32 clocks, sets flag.
// - Monitor mode with test voltage disables watchdog.
// - Break state with reset-pin test voltage disables.
// - Stop instruction clears the prescaler.
// - Service location reads reset vector low byte.
// - Prescaler cleared 4096 clocks after power-up.
// - Internal reset clears prescaler and counter.
// - Reset vector fetch clears the prescaler.
// - Disable bit from configuration inhibits watchdog.
// - No processor interrupt; timeout only resets. Here the flag also drives irq_o when the mask bit is set.
// - Watchdog keeps counting during wait mode.
// - Stop gates oscillator clock, clears prescaler.
// - Stop honoured only when stop-enable bit set.
//
// Local design decision: register access over APB.
`include "cwd_defines.svh"
module cwd_top #(
  parameter int OSC_DIV = 1
) (
  input  wire logic                   clk_i,
  input  wire logic                   rstn_i,
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [`CWD_ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]            pwdata_i,
  output logic      [31:0]            prdata_o,
  output logic                        pready_o,
  output logic                        pslverr_o,
  input  wire logic [7:0]             reset_vector_low_i,
  input  wire logic                   vector_fetch_i,
  input  wire logic                   internal_reset_i,
  input  wire logic                   stop_req_i,
  input  wire logic                   wake_i,
  input  wire logic                   wait_mode_i,
  input  wire logic                   monitor_mode_i,
  input  wire logic                   break_state_i,
  input  wire logic                   rst_pin_high_voltage_i,
  input  wire logic                   interrupt_pin_one_high_voltage_i,
  output logic                        sys_reset_o,
  output logic                        rst_pin_o,
  output logic                        rst_pin_oe_o,
  output logic                        stopped_o,
  output logic                        irq_o
);
  initial begin
    if (OSC_DIV < 1) $error("cwd_top: OSC_DIV must be at least 1");
  end

  // ----------------------------------------
  // Oscillator clock enable and pin inputs
  // ----------------------------------------
  localparam int DIV_W = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;
  logic [DIV_W-1:0] div_reg;
  logic             osc_tick;
  logic [1:0]       hv_sync;
  wire              rst_hv = hv_sync[0];
  wire              irq_hv = hv_sync[1];
  assign osc_tick = (div_reg == DIV_W'(OSC_DIV - 1));
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i)       div_reg <= '0;
    else if (osc_tick) div_reg <= '0;
    else               div_reg <= DIV_W'(div_reg + 1'b1);
  end
  cwd_sync #(.WIDTH(2)) u_sync (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .async_i ({interrupt_pin_one_high_voltage_i, rst_pin_high_voltage_i}),
    .sync_o  (hv_sync)
  );

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  logic [2:0]  cfg_reg;
  logic [0:0]  status_reg;
  logic [0:0]  mask_reg;
  logic [5:0]  cnt_reg;
  logic [11:0] presc;
  wire [`CWD_ADDR_W-1:0] a_cfg  = {`CWD_IDX_CONFIG, 2'b00};
  wire [`CWD_ADDR_W-1:0] a_stat = {`CWD_IDX_STATUS, 2'b00};
  wire [`CWD_ADDR_W-1:0] a_mask = {`CWD_IDX_MASK, 2'b00};
  wire [`CWD_ADDR_W-1:0] a_cnt  = {`CWD_IDX_COUNT, 2'b00};
  wire [`CWD_ADDR_W-1:0] a_svc  = {`CWD_IDX_SERVICE, 2'b00};
  wire hit_cfg  = (paddr_i == a_cfg);
  wire hit_stat = (paddr_i == a_stat);
  wire hit_mask = (paddr_i == a_mask);
  wire hit_cnt  = (paddr_i == a_cnt);
  wire hit_svc  = (paddr_i == a_svc);
  wire mapped   = hit_cfg | hit_stat | hit_mask | hit_cnt | hit_svc;
  wire setup    = psel_i & ~penable_i;
  wire done     = psel_i & penable_i & pready_o;
  wire wr_done  = done & pwrite_i & mapped;
  wire rd_done  = done & ~pwrite_i & mapped;
  wire service_wr = wr_done & hit_svc;
  wire stat_rd    = rd_done & hit_stat;
  // Service location reads back the vector byte, never watchdog state
  wire [31:0] rd_mux = hit_svc  ? {24'h0, reset_vector_low_i} :
                       hit_cfg  ? {29'h0, cfg_reg} :
                       hit_stat ? {31'h0, status_reg} :
                       hit_mask ? {31'h0, mask_reg} :
                       hit_cnt  ? {26'h0, cnt_reg} : 32'h0;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= setup;
      pslverr_o <= setup & ~mapped;
      if (setup) prdata_o <= pwrite_i ? 32'h0 : rd_mux;
    end
  end

  // ----------------------------------------
  // Configuration and mask registers
  // ----------------------------------------
  wire cfg_wr  = wr_done & hit_cfg;
  wire mask_wr = wr_done & hit_mask;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_reg  <= `CWD_CFG_RESET;
      mask_reg <= 1'b0;
    end else begin
      if (cfg_wr)  cfg_reg  <= pwdata_i[2:0];
      if (mask_wr) mask_reg <= pwdata_i[0];
    end
  end
  wire watchdog_disable_bit = cfg_reg[`CWD_CFG_DIS];
  wire timeout_rate_select  = cfg_reg[`CWD_CFG_RATE];
  wire stop_enable          = cfg_reg[`CWD_CFG_STOPEN];

  // ----------------------------------------
  // Inhibit, stop and power-up clear
  // ----------------------------------------
  cwd_pkg::cwd_state_t state_reg;
  cwd_pkg::cwd_state_t state_next;
  logic [12:0] por_cnt;
  logic        por_done;
  wire inhibit = watchdog_disable_bit
               | (monitor_mode_i & (rst_hv | irq_hv))
               | (break_state_i & rst_hv);
  wire stop_take = stop_req_i & stop_enable;
  wire por_hit   = ~por_done & osc_tick & (por_cnt == 13'(`CWD_POR_OSC - 1));
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stopped_o <= 1'b0;
      por_cnt   <= 13'h0;
      por_done  <= 1'b0;
    end else begin
      if (stop_take)  stopped_o <= 1'b1;
      else if (wake_i) stopped_o <= 1'b0;
      if (por_hit) por_done <= 1'b1;
      else if (~por_done & osc_tick) por_cnt <= 13'(por_cnt + 1'b1);
    end
  end

  // ----------------------------------------
  // Prescaler and overflow counter
  // ----------------------------------------
  wire in_pulse  = (state_reg == cwd_pkg::CWD_PULSE);
  wire int_rst   = internal_reset_i | in_pulse;
  // Oscillator is gated while stopped; wait mode does not gate it
  wire osc_run   = osc_tick & ~stopped_o & ~inhibit;
  wire pre_clr   = int_rst | stop_take | stopped_o | inhibit
                 | vector_fetch_i | por_hit;
  wire [11:0] tap_mask = timeout_rate_select ? `CWD_LONG_MASK : `CWD_SHORT_MASK;
  wire [11:0] tap_end  = timeout_rate_select ? `CWD_LONG_END  : `CWD_SHORT_END;
  wire carry    = osc_run & ((presc & tap_mask) == tap_mask);
  // Overflow lands 16 clocks before the counter would wrap
  wire overflow = osc_run & ~in_pulse & (cnt_reg == `CWD_CNT_FULL)
                & ((presc & tap_mask) == tap_end);
  cwd_prescaler #(.WIDTH(12)) u_presc (
    .clk_i         (clk_i),
    .rstn_i        (rstn_i),
    .tick_i        (osc_run),
    .clear_all_i   (pre_clr),
    .clear_upper_i (service_wr),
    .value_o       (presc)
  );
  wire [5:0] cnt_next = (int_rst | service_wr | inhibit) ? 6'h0 :
                        carry ? 6'(cnt_reg + 1'b1) : cnt_reg;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) cnt_reg <= 6'h0;
    else         cnt_reg <= cnt_next;
  end

  // ----------------------------------------
  // Reset pulse sequencer
  // ----------------------------------------
  logic [5:0] pulse_cnt;
  wire pulse_end = in_pulse & osc_tick & (pulse_cnt == 6'(`CWD_PIN_LOW_OSC - 1));
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cwd_pkg::CWD_RUN:   if (overflow) state_next = cwd_pkg::CWD_PULSE;
      cwd_pkg::CWD_PULSE: if (pulse_end) state_next = cwd_pkg::CWD_RUN;
      default:            state_next = cwd_pkg::CWD_RUN;
    endcase
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg    <= cwd_pkg::CWD_RUN;
      pulse_cnt    <= 6'h0;
      sys_reset_o  <= 1'b0;
      rst_pin_o    <= 1'b0;
      rst_pin_oe_o <= 1'b0;
    end else begin
      state_reg    <= state_next;
      sys_reset_o  <= (state_next == cwd_pkg::CWD_PULSE);
      rst_pin_oe_o <= (state_next == cwd_pkg::CWD_PULSE);
      rst_pin_o    <= 1'b0;
      if (overflow)      pulse_cnt <= 6'h0;
      else if (in_pulse & osc_tick) pulse_cnt <= 6'(pulse_cnt + 1'b1);
    end
  end

  // ----------------------------------------
  // Reset-source flag, mask and status line
  // ----------------------------------------
  wire [0:0] status_next = overflow ? 1'b1 : (stat_rd ? 1'b0 : status_reg);
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status_reg <= 1'b0;
      irq_o      <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq_o      <= |(status_next & mask_reg);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_ovf;
    overflow ##1 (sys_reset_o && rst_pin_oe_o);
  endsequence
  property p_ovf_reset;
    overflow |-> s_ovf;
  endproperty
  a_ovf_reset: assert property (p_ovf_reset) else $error("overflow gave no reset");

  property p_pulse_len;
    pulse_end |=> !rst_pin_oe_o && !sys_reset_o;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("reset pulse too long");

  property p_pulse_hold;
    (in_pulse && !pulse_end) |=> rst_pin_oe_o && !rst_pin_o;
  endproperty
  a_pulse_hold: assert property (p_pulse_hold) else $error("reset pin released early");

  property p_flag_set;
    overflow |=> status_reg[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("watchdog flag not set");

  property p_service;
    service_wr |=> cnt_reg == 6'h0 && (presc & ~`CWD_PRE_KEEP) == 12'h0;
  endproperty
  a_service: assert property (p_service) else $error("service did not clear");

  property p_inhibit;
    inhibit |=> cnt_reg == 6'h0 && presc == 12'h0 && !overflow;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("watchdog ran while inhibited");

  property p_stop;
    stop_take |=> presc == 12'h0 && stopped_o;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not clear prescaler");

  property p_stop_gate;
    stopped_o && !wake_i |=> $stable(cnt_reg) || cnt_reg == 6'h0;
  endproperty
  a_stop_gate: assert property (p_stop_gate) else $error("counted while stopped");

  property p_vector_rd;
    (setup && !pwrite_i && hit_svc) |=> prdata_o == {24'h0, $past(reset_vector_low_i)};
  endproperty
  a_vector_rd: assert property (p_vector_rd) else $error("service read wrong");

  property p_int_rst;
    internal_reset_i |=> cnt_reg == 6'h0 && presc == 12'h0;
  endproperty
  a_int_rst: assert property (p_int_rst) else $error("internal reset did not clear");

  property p_fetch;
    vector_fetch_i |=> presc == 12'h0;
  endproperty
  a_fetch: assert property (p_fetch) else $error("vector fetch did not clear");

  property p_set_wins;
    (overflow && stat_rd) |=> status_reg[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag lost on clear");

  property p_por;
    por_hit |=> presc == 12'h0;
  endproperty
  a_por: assert property (p_por) else $error("power-up clear missing");

  // Wait mode must not slow or stop the prescaler
  property p_wait_run;
    (wait_mode_i && osc_run && !pre_clr && !service_wr) |=> presc == $past(presc) + 12'h001;
  endproperty
  a_wait_run: assert property (p_wait_run) else $error("prescaler idle in wait mode");
endmodule

// *** cop_watchdog_timer_test.sv ***
// Self-checking testbench of the watchdog timer
`include "cwd_defines.svh"
module cop_watchdog_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  vec = 8'h00;
  logic        vfetch = 1'b0;
  logic        ireset = 1'b0;
  logic        stop_req = 1'b0;
  logic        wake = 1'b0;
  logic        waitm = 1'b0;
  logic [3:0]  pins = 4'h0;
  logic        sys_rst;
  logic        pin;
  logic        pin_oe;
  logic        stopped;
  logic        irq;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          n;
  logic [7:0]  seed = 8'h62;
  logic [31:0] rd;
  logic        err;
  logic [5:0]  pats [7] = '{6'h00, 6'h20, 6'h10, 6'h0a, 6'h09, 6'h06, 6'h05};
  localparam int TO_SHORT = (1 << 13) - (1 << 4);

  always #25 clk = ~clk;

  cwd_top #(.OSC_DIV(1)) cwd_top_inst (
    .clk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .reset_vector_low_i(vec), .vector_fetch_i(vfetch), .internal_reset_i(ireset),
    .stop_req_i(stop_req), .wake_i(wake), .wait_mode_i(waitm), .monitor_mode_i(pins[3]),
    .break_state_i(pins[2]), .rst_pin_high_voltage_i(pins[1]), .interrupt_pin_one_high_voltage_i(pins[0]),
    .sys_reset_o(sys_rst), .rst_pin_o(pin), .rst_pin_oe_o(pin_oe), .stopped_o(stopped), .irq_o(irq));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [17:0] ba(input logic [15:0] idx);
    return {idx, 2'b00};
  endfunction

  // Counter value after some cycles from a service, given {rate,dis,mon,brk,rst_hv,irq_hv}
  function automatic logic [31:0] exp_cnt(input logic [5:0] p, input int cyc);
    if (p[4] || (p[3] && (p[1] || p[0])) || (p[2] && p[1])) return 32'h0;
    return p[5] ? 32'(cyc / 4096) : 32'(cyc / 128);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [17:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask

  task automatic service();
    seed = lfsr(seed);
    apb(1'b1, ba(`CWD_IDX_SERVICE), {24'h0, seed});
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    $display("[ERR] %0t run did not finish in time", $time);
    summarize();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rchk(ba(`CWD_IDX_CONFIG), 32'h0, "config reset");
    rchk(ba(`CWD_IDX_STATUS), 32'h0, "status reset");
    rchk(ba(`CWD_IDX_COUNT), 32'h0, "count reset");
    rchk(ba(16'h0004), 32'h0, "unmapped read");
    chk(32'(err), 32'h1, "unmapped error");
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      vec <= seed;
      rchk(ba(`CWD_IDX_SERVICE), {24'h0, seed}, "service read");
    end
    apb(1'b1, ba(`CWD_IDX_CONFIG), 32'h7);
    rchk(ba(`CWD_IDX_CONFIG), 32'h7, "config readback");
    apb(1'b1, ba(`CWD_IDX_CONFIG), 32'h0);
    repeat (4200) @(posedge clk);
    for (int i = 0; i < 3; i++) begin
      service();
      repeat (4000) @(posedge clk);
    end
    chk(32'(sys_rst), 32'h0, "serviced no reset");
    rchk(ba(`CWD_IDX_STATUS), 32'h0, "serviced no flag");
    foreach (pats[i]) begin
      apb(1'b1, ba(`CWD_IDX_CONFIG), {30'h0, pats[i][5], pats[i][4]});
      service();
      pins <= pats[i][3:0];
      repeat (1000) @(posedge clk);
      rchk(ba(`CWD_IDX_COUNT), exp_cnt(pats[i], 1000), "count by mode");
      pins <= 4'h0;
    end
    apb(1'b1, ba(`CWD_IDX_CONFIG), 32'h0);
    service();
    repeat (1000) @(posedge clk);
    ireset <= 1'b1;
    repeat (2) @(posedge clk);
    ireset <= 1'b0;
    rchk(ba(`CWD_IDX_COUNT), 32'h0, "internal reset");
    service();
    repeat (300) @(posedge clk);
    vfetch <= 1'b1;
    repeat (600) @(posedge clk);
    rchk(ba(`CWD_IDX_COUNT), 32'h2, "vector fetch hold");
    vfetch <= 1'b0;
    apb(1'b1, ba(`CWD_IDX_CONFIG), 32'h4);
    service();
    repeat (300) @(posedge clk);
    stop_req <= 1'b1;
    @(posedge clk);
    stop_req <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'(stopped), 32'h1, "stop entered");
    repeat (600) @(posedge clk);
    rchk(ba(`CWD_IDX_COUNT), 32'h2, "frozen in stop");
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'(stopped), 32'h0, "stop left");
    repeat (100) @(posedge clk);
    rchk(ba(`CWD_IDX_COUNT), 32'h2, "prescaler cleared by stop");
    apb(1'b1, ba(`CWD_IDX_CONFIG), 32'h0);
    stop_req <= 1'b1;
    @(posedge clk);
    stop_req <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'(stopped), 32'h0, "stop refused");
    waitm <= 1'b1;
    service();
    n = 0;
    while (sys_rst !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n >= TO_SHORT - 20 && n <= TO_SHORT + 4), 32'h1, "timeout length");
    chk({30'h0, pin_oe, pin}, 32'h2, "reset pin driven low");
    n = 0;
    while (sys_rst === 1'b1) begin
      n++;
      @(posedge clk);
    end
    chk(32'(n), 32'd32, "reset pulse length");
    waitm <= 1'b0;
    chk(32'(irq), 32'h0, "flag masked");
    apb(1'b1, ba(`CWD_IDX_MASK), 32'h1);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1, "flag unmasked");
    rchk(ba(`CWD_IDX_STATUS), 32'h1, "watchdog flag");
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0, "flag cleared");
    rchk(ba(`CWD_IDX_STATUS), 32'h0, "status after clear");
    summarize();
  end
endmodule
